// [sdm_cmp_model.sv]
// Behavioural analog comparator facing the supply drop monitor
module sdm_cmp_model (
    // Detector controls
    input  wire logic        detector_on,
    input  wire logic        reference_on,
    input  wire logic [2:0]  threshold_select,
    input  wire logic        external_sense_pin_sel,
    // Voltages in millivolts
    input  wire logic [15:0] supply_mv,
    input  wire logic [15:0] pin_mv,
    // Comparator result
    output logic             cmp_below
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lvl [8] = '{16'd1040, 16'd2200, 16'd2400, 16'd2700,
                             16'd3000, 16'd3300, 16'd3600, 16'd4000};
    logic        tgl = 1'b0;
    // Unpowered output is junk, so it wanders off the clock grid
    always #7 tgl = ~tgl;
    always_comb begin
        if (!(detector_on && reference_on)) cmp_below = tgl;
        else if (external_sense_pin_sel) cmp_below = pin_mv <= lvl[0];
        else cmp_below = supply_mv < lvl[threshold_select];
    end
endmodule

// [sdm_ctrl.v]
// Supply drop monitor control: AXI4-Lite registers, detector gating, request and wake
`include "sdm_defines.vh"

module sdm_ctrl #(
    parameter ADDR_W   = 8,
    parameter CNT_W    = 16,
    parameter [CNT_W-1:0] QUAL_CYC = `SDM_QUALIFY_CYC
) (
    // Clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Power modes
    input  wire              sleep_mode,
    input  wire              idle_mode,
    // Analog comparator side
    input  wire              cmp_below_async,
    output reg               detector_on,
    output reg               reference_on,
    output reg               bandgap_buffer_on,
    output reg  [2:0]        threshold_select,
    output reg               external_sense_pin_sel,
    // Interrupt and wake
    output reg               shared_irq_req,
    output reg               wake_req,
    output reg               irq
);

    ////////////////////////////////////////////////////////////////////////
    // State
    reg  [2:0]           sel_q;
    reg                  on_q;
    reg                  bgap_q;
    reg                  flag_q;
    reg                  irq_en_q;
    reg                  flag_prev_q;
    reg                  below_prev_q;
    reg  [`SDM_EVT_W-1:0] evt_q;
    reg  [`SDM_EVT_W-1:0] mask_q;
    reg                  aw_held_q;
    reg                  w_held_q;
    reg  [ADDR_W-1:0]    awaddr_q;
    reg  [31:0]          wdata_q;
    reg  [3:0]           wstrb_q;

    wire                 below;
    wire                 qualified;
    wire                 active;
    wire                 do_write;
    wire                 do_read;
    wire                 sw_flag_wr;
    wire                 stat_rd;
    wire [`SDM_EVT_W-1:0] evt_set;
    reg  [31:0]          rd_word;
    reg                  rd_hit;
    reg                  wr_hit;

    // Sleep wins over the enable bit
    assign active = on_q & ~sleep_mode;

    ////////////////////////////////////////////////////////////////////////
    // Comparator path
    sdm_qualify #(
        .CNT_W    (CNT_W),
        .QUAL_CYC (QUAL_CYC)
    ) u_qualify (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .cmp_below_async (cmp_below_async),
        .active          (active),
        .below_q         (below),
        .qualified_q     (qualified)
    );

    ////////////////////////////////////////////////////////////////////////
    // Analog controls, all registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            detector_on            <= 1'b0;
            reference_on           <= 1'b0;
            bandgap_buffer_on      <= 1'b0;
            threshold_select       <= `SDM_SEL_SENSE_PIN;
            external_sense_pin_sel <= 1'b1;
        end else begin
            detector_on            <= active;
            reference_on           <= active;
            bandgap_buffer_on      <= bgap_q;
            threshold_select       <= sel_q;
            external_sense_pin_sel <= (sel_q == `SDM_SEL_SENSE_PIN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI write channel: address and data taken in either order
    assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awaddr_q      <= {ADDR_W{1'b0}};
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SDM_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `SDM_RESP_OKAY : `SDM_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @* begin
        case (awaddr_q)
            `SDM_ADDR_CTRL,
            `SDM_ADDR_IRQCTL,
            `SDM_ADDR_EVT_STAT,
            `SDM_ADDR_EVT_MASK: wr_hit = 1'b1;
            default:            wr_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and interrupt-control registers; only byte lane 0 is stored
    assign sw_flag_wr = do_write & wstrb_q[0] & (awaddr_q == `SDM_ADDR_IRQCTL);

    always @(posedge aclk) begin
        if (!aresetn) begin
            sel_q  <= `SDM_SEL_SENSE_PIN;
            on_q   <= 1'b0;
            bgap_q <= 1'b0;
            mask_q <= `SDM_EVT_RESET;
        end else if (do_write & wstrb_q[0]) begin
            if (awaddr_q == `SDM_ADDR_CTRL) begin
                sel_q  <= wdata_q[`SDM_CTRL_SEL_MSB:`SDM_CTRL_SEL_LSB];
                on_q   <= wdata_q[`SDM_CTRL_ON_BIT];
                bgap_q <= wdata_q[`SDM_CTRL_BGAP_BIT];
            end
            if (awaddr_q == `SDM_ADDR_EVT_MASK) begin
                mask_q <= wdata_q[`SDM_EVT_W-1:0];
            end
        end
    end

    // Request flag: hardware set wins over a software clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_q   <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (sw_flag_wr) begin
                irq_en_q <= wdata_q[`SDM_IRQ_EN_BIT];
            end
            if (qualified) begin
                flag_q <= 1'b1;
            end else if (sw_flag_wr) begin
                flag_q <= wdata_q[`SDM_IRQ_FLAG_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared request and wake; wake ignores the enable bit
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_prev_q    <= 1'b0;
            below_prev_q   <= 1'b0;
            shared_irq_req <= 1'b0;
            wake_req       <= 1'b0;
        end else begin
            flag_prev_q    <= flag_q;
            below_prev_q   <= below;
            shared_irq_req <= flag_q & irq_en_q;
            wake_req       <= flag_q & ~flag_prev_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events, cleared by a read of the status register
    assign evt_set[`SDM_EVT_BELOW] = below & ~below_prev_q;
    assign evt_set[`SDM_EVT_FLAG]  = qualified;
    assign evt_set[`SDM_EVT_WAKE]  = flag_q & ~flag_prev_q;
    assign stat_rd = do_read & (s_axi_araddr == `SDM_ADDR_EVT_STAT);

    always @(posedge aclk) begin
        if (!aresetn) begin
            evt_q <= `SDM_EVT_RESET;
            irq   <= 1'b0;
        end else begin
            evt_q <= (stat_rd ? {`SDM_EVT_W{1'b0}} : evt_q) | evt_set;
            irq   <= |(((stat_rd ? {`SDM_EVT_W{1'b0}} : evt_q) | evt_set) & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI read channel: one read at a time, address sampled at handshake
    assign do_read = s_axi_arvalid & s_axi_arready;

    always @* begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `SDM_ADDR_CTRL: begin
                // Bits 7 and 6 stay zero
                rd_word[`SDM_CTRL_SEL_MSB:`SDM_CTRL_SEL_LSB] = sel_q;
                rd_word[`SDM_CTRL_BGAP_BIT]  = bgap_q;
                rd_word[`SDM_CTRL_ON_BIT]    = on_q;
                rd_word[`SDM_CTRL_BELOW_BIT] = below;
            end
            `SDM_ADDR_IRQCTL: begin
                rd_word[`SDM_IRQ_FLAG_BIT] = flag_q;
                rd_word[`SDM_IRQ_EN_BIT]   = irq_en_q;
            end
            `SDM_ADDR_EVT_STAT: begin
                rd_word[`SDM_EVT_W-1:0] = evt_q;
            end
            `SDM_ADDR_EVT_MASK: begin
                rd_word[`SDM_EVT_W-1:0] = mask_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `SDM_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `SDM_RESP_OKAY : `SDM_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Idle needs no gating: detector keeps running unless sleeping
    wire unused_idle = idle_mode;

endmodule

// [sdm_ctrl_asserts.sv]
// Concurrent checks on the supply drop monitor control ports
module sdm_ctrl_asserts #(
    parameter CNT_W = 16,
    parameter [CNT_W-1:0] QUAL_CYC = 16'd100
) (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Write response
    input wire        s_axi_bvalid,
    // Detector side
    input wire        sleep_mode,
    input wire        detector_on,
    input wire        reference_on,
    input wire        bandgap_buffer_on,
    input wire [2:0]  threshold_select,
    input wire        external_sense_pin_sel,
    // Interrupt and wake
    input wire        shared_irq_req,
    input wire        wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] off_cnt_q;
    ////////////////////////////////////////////////////////////////////////////
    // Saturates so a long idle detector never wraps back to small counts
    always @(posedge aclk) begin
        if (!aresetn || detector_on) off_cnt_q <= 8'h00;
        else if (off_cnt_q != 8'hff) off_cnt_q <= off_cnt_q + 8'h01;
    end
    sequence bus_wr_recent;
        s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    sleep_off_a: assert property (sleep_mode |=> !detector_on)
        else $error("detector on during sleep");
    ref_auto_a: assert property (reference_on == detector_on)
        else $error("reference not following detector");
    pin_sel_a: assert property (external_sense_pin_sel == (threshold_select == 3'h0))
        else $error("sense pin select wrong");
    wake_pulse_a: assert property (wake_req |=> !wake_req)
        else $error("wake longer than one cycle");
    cfg_write_a: assert property ($changed({bandgap_buffer_on, threshold_select})
        |-> bus_wr_recent) else $error("config changed without write");
    det_cause_a: assert property ($changed(detector_on) |-> $past(s_axi_bvalid)
        || $past(sleep_mode) != $past(sleep_mode, 2)) else $error("detector moved alone");
    qual_wake_a: assert property (wake_req && {8'h00, off_cnt_q} > QUAL_CYC + 16'd4
        |-> bus_wr_recent) else $error("wake without qualified low voltage");
    irq_drop_a: assert property ($fell(shared_irq_req) |-> bus_wr_recent)
        else $error("shared request dropped without write");
endmodule

bind sdm_ctrl sdm_ctrl_asserts #(.CNT_W(CNT_W), .QUAL_CYC(QUAL_CYC)) u_chk (
    .aclk, .aresetn, .s_axi_bvalid, .sleep_mode, .detector_on, .reference_on,
    .bandgap_buffer_on, .threshold_select, .external_sense_pin_sel,
    .shared_irq_req, .wake_req);

// [sdm_defines.vh]
// Register map, field layout and timing constants of the supply drop monitor
// Summary of operation
// - Threshold code 000 compares the external sense pin against a fixed 1.04V reference
// - Codes 001 to 111 pick supply thresholds 2.2V up to 4.0V
// - Status bit 5 reads 1 while monitored voltage is below threshold
// - Bit 4 turns the detector on when 1, fully off when 0
// - Bit 3 drives the bandgap buffer enable
// - Control bits 7 and 6 always read zero
// - Detector reference is enabled automatically whenever the detector runs
// - Sleep mode forces the detector off regardless of enable
// - Status follows the comparator without hysteresis
// - Request feeds the shared multi-function interrupt
// - Request flag sets after a qualification delay of continuous low voltage, or by a software write of 1
// - In idle with detector enabled, low voltage sets the flag and wakes
// - Any 0 to 1 change of the flag wakes, regardless of enable
`ifndef SDM_DEFINES_VH
`define SDM_DEFINES_VH

// Byte addresses
`define SDM_ADDR_CTRL       8'h00
`define SDM_ADDR_IRQCTL     8'h04
`define SDM_ADDR_EVT_STAT   8'h08
`define SDM_ADDR_EVT_MASK   8'h0c

// Control register fields
`define SDM_CTRL_SEL_LSB    0
`define SDM_CTRL_SEL_MSB    2
`define SDM_CTRL_BGAP_BIT   3
`define SDM_CTRL_ON_BIT     4
`define SDM_CTRL_BELOW_BIT  5
`define SDM_CTRL_RESET      8'h00
`define SDM_SEL_SENSE_PIN   3'h0

// Interrupt control fields
`define SDM_IRQ_FLAG_BIT    0
`define SDM_IRQ_EN_BIT      1
`define SDM_IRQCTL_RESET    2'h0

// Event status bits
`define SDM_EVT_BELOW       0
`define SDM_EVT_FLAG        1
`define SDM_EVT_WAKE        2
`define SDM_EVT_W           3
`define SDM_EVT_RESET       3'h0

// Timing
`define SDM_CLK_MHZ         100
`define SDM_T_QUALIFY_NS    1000
// Qualify time in clock cycles, sized to match the counter width
`define SDM_QUALIFY_CYC     16'd100

// AXI responses
`define SDM_RESP_OKAY       2'h0
`define SDM_RESP_SLVERR     2'h2

`endif

// [sdm_qualify.v]
// Comparator synchroniser, gating and qualification delay counter
`include "sdm_defines.vh"

module sdm_qualify #(
    parameter CNT_W   = 16,
    parameter [CNT_W-1:0] QUAL_CYC = `SDM_QUALIFY_CYC
) (
    // Clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // Comparator and control
    input  wire             cmp_below_async,
    input  wire             active,
    // Results
    output reg              below_q,
    output reg              qualified_q
);

    ////////////////////////////////////////////////////////////////////////
    reg             sync1_q;
    reg             sync2_q;
    reg [CNT_W-1:0] cnt_q;

    // Two stages; first stage read by second only
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= cmp_below_async;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // No hysteresis: status tracks the comparator while active
    always @(posedge aclk) begin
        if (!aresetn) begin
            below_q <= 1'b0;
        end else begin
            below_q <= sync2_q & active;
        end
    end

    // Qualified pulse once below has held for QUAL_CYC cycles
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q       <= {CNT_W{1'b0}};
            qualified_q <= 1'b0;
        end else begin
            qualified_q <= 1'b0;
            if (!below_q) begin
                cnt_q <= {CNT_W{1'b0}};
            end else if (cnt_q < QUAL_CYC) begin
                cnt_q <= cnt_q + 1'b1;
                if (cnt_q == QUAL_CYC - 1'b1) begin
                    qualified_q <= 1'b1;
                end
            end
        end
    end

endmodule

// [tb.sv]
// Self-checking testbench for the supply drop monitor control block
`include "sdm_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 0, aresetn = 0, sleep_mode = 0, idle_mode = 0, bg = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 0;
    logic [15:0] vdd = 16'd5000, vpin = 16'd5000;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [2:0]  threshold_select;
    wire         cmp_below_async, detector_on, reference_on, bandgap_buffer_on;
    wire         external_sense_pin_sel, shared_irq_req, wake_req, irq;
    int          failures = 0, comparisons = 0, wakes = 0;
    logic [33:0] expq [$];
    localparam logic [7:0] C = `SDM_ADDR_CTRL, I = `SDM_ADDR_IRQCTL;
    localparam logic [7:0] S = `SDM_ADDR_EVT_STAT, M = `SDM_ADDR_EVT_MASK;
    localparam logic [1:0] OK = `SDM_RESP_OKAY, ER = `SDM_RESP_SLVERR;
    ////////////////////////////////////////////////////////////////////////////
    sdm_ctrl #(.QUAL_CYC(16'd4)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sleep_mode, .idle_mode, .cmp_below_async, .detector_on, .reference_on,
        .bandgap_buffer_on, .threshold_select, .external_sense_pin_sel,
        .shared_irq_req, .wake_req, .irq);
    sdm_cmp_model u_cmp (.detector_on, .reference_on, .threshold_select,
        .external_sense_pin_sel, .supply_mv(vdd), .pin_mv(vpin), .cmp_below(cmp_below_async));
    initial forever #5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [33:0] got, logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Address and data go up together; each drops at its own ready
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
        int n;
        @(posedge aclk);
        expq.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0;
        if (n == 50) begin failures++; stop_test(); end
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r);
        int n;
        @(posedge aclk);
        expq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0;
        if (n == 50) begin failures++; stop_test(); end
    endtask
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) check("bresp", {s_axi_bresp, 32'h0}, expq.pop_front());
        if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, expq.pop_front());
        if (wake_req) wakes++;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(79));
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        check("pin_rst", external_sense_pin_sel, 1);
        rd(C, 32'h0, OK);
        for (int s = 0; s < 8; s++) begin
            bg = $urandom % 2;
            wr(C, {24'h0, 2'b11, 1'b1, 1'b0, bg, s[2:0]}, OK);
            rd(C, {24'h0, 4'h0, bg, s[2:0]}, OK);
            check("sel", threshold_select, s[2:0]);
            check("pin", external_sense_pin_sel, s == 0);
            check("bgap", bandgap_buffer_on, bg);
        end
        wr(I, 32'h0, OK);
        wr(M, 32'h7, OK);
        wr(I, 32'h2, OK);
        wr(C, 32'h11, OK);
        repeat (8) @(posedge aclk);
        check("det", detector_on, 1);
        check("ref", reference_on, 1);
        vdd <= 16'd2000;
        repeat (2) @(posedge aclk);
        vdd <= 16'd5000;
        repeat (8) @(posedge aclk);
        rd(I, 32'h2, OK);
        rd(S, 32'h1, OK);
        vdd <= 16'd2000;
        repeat (15) @(posedge aclk);
        rd(C, 32'h31, OK);
        rd(I, 32'h3, OK);
        check("sirq", shared_irq_req, 1);
        check("irq", irq, 1);
        rd(S, 32'h7, OK);
        repeat (3) @(posedge aclk);
        check("irq_clr", irq, 0);
        check("wake1", wakes, 1);
        wr(I, 32'h3, OK);
        sleep_mode <= 1;
        idle_mode <= 1;
        repeat (4) @(posedge aclk);
        check("det_slp", detector_on, 0);
        check("ref_slp", reference_on, 0);
        rd(C, 32'h11, OK);
        sleep_mode <= 0;
        repeat (15) @(posedge aclk);
        check("wake_sup", wakes, 1);
        vdd <= 16'd5000;
        repeat (6) @(posedge aclk);
        wr(M, 32'h0, OK);
        wr(I, 32'h2, OK);
        vdd <= 16'd2000;
        repeat (15) @(posedge aclk);
        check("wake_idle", wakes, 2);
        check("irq_mask", irq, 0);
        vdd <= 16'd5000;
        repeat (6) @(posedge aclk);
        wr(I, 32'h0, OK);
        wr(I, 32'h1, OK);
        repeat (3) @(posedge aclk);
        check("wake_sw", wakes, 3);
        wr(C, 32'h10, OK);
        vpin <= 16'd1000;
        repeat (8) @(posedge aclk);
        rd(C, 32'h30, OK);
        wr(C, 32'h01, OK);
        repeat (4) @(posedge aclk);
        check("det_off", detector_on, 0);
        rd(C, 32'h01, OK);
        // Software wake with the detector long off
        wr(I, 32'h0, OK);
        wr(I, 32'h1, OK);
        repeat (3) @(posedge aclk);
        check("wake_off", wakes, 4);
        wr(8'h10, $urandom, ER);
        rd(8'h10, 32'h0, ER);
        stop_test();
    end
endmodule
